// ### stc_pkg.sv
// Shared types and constants of the scope trigger controller
package stc_pkg;
	localparam int NCH = 16;
	localparam int SW = 8;
	localparam int TW = 16;
	localparam int RW = 11;
	localparam logic [RW-1:0] REC_LEN_S = 11'h1f4;
	localparam logic [RW-1:0] REC_LEN_M = 11'h3e8;
	localparam logic [RW-1:0] REC_LEN_L = 11'h7d0;
	localparam logic [31:0] PCT_FULL = 32'h64;
	localparam int CLK_NS = 10;
	localparam int AUTO_BASE_NS = 100000;
	localparam int AUTO_BASE_CYC = (AUTO_BASE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [TW-1:0] HO_MIN_SAMP = 16'h000a;
	localparam logic [TW-1:0] HO_MAX_SAMP = 16'h0fa0;
	localparam logic [1:0] DLY_BY_TIME = 2'h1;
	localparam logic [1:0] DLY_BY_EVT = 2'h2;

	typedef logic [NCH-1:0][SW-1:0] stc_samp_type;
	typedef enum logic [2:0] {TT_EDGE, TT_PULSE, TT_PATTERN, TT_STATE, TT_SEQUENCE} stc_ttype_type;
	typedef enum logic [1:0] {OP_AND, OP_OR, OP_NAND, OP_NOR} stc_op_type;
	typedef enum logic [1:0] {Q_TRUE, Q_LONGER, Q_SHORTER, Q_WITHIN} stc_qual_type;
	typedef enum logic [1:0] {W_LESS, W_MORE, W_WITHIN, W_OUTSIDE} stc_when_type;
	typedef enum logic [2:0] {ST_IDLE, ST_FILL, ST_ARMED, ST_DELAY, ST_POST, ST_HOLD} stc_state_type;

	typedef struct packed {
		stc_ttype_type ttype;
		logic [3:0] src;
		logic slope;
		logic [SW-1:0] level;
		logic glitch;
		stc_when_type pwhen;
		logic [TW-1:0] tmin;
		logic [TW-1:0] tmax;
		stc_op_type op;
		stc_qual_type qual;
		logic [NCH-1:0] care;
		logic [NCH-1:0] want;
		logic [3:0] clk_src;
		logic [NCH-1:0] stop_care;
		logic [NCH-1:0] stop_want;
	} stc_cfg_type;

	typedef struct packed {
		stc_samp_type data;
		logic [31:0] stamp;
		logic [RW-1:0] addr;
	} stc_wr_type;
endpackage : stc_pkg

// ### stc_trig_eval.sv
// Trigger event recognizer for one trigger system (all five types)
`timescale 1ns/1ps
module stc_trig_eval import stc_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	input wire stc_samp_type samp_i,
	input wire logic [NCH-1:0] lvl_i,
	input wire stc_cfg_type cfg_i,
	output logic hit_o
);
	logic above_q, above_d, cond_q, cond_d, stop_q, stop_d, clkl_q, clkl_d;
	logic run_q, run_d, hit_q, hit_d;
	logic [TW-1:0] pw_q, pw_d, pc_q, pc_d, sc_q, sc_d;

	function automatic logic comb_f(logic [NCH-1:0] l, logic [NCH-1:0] c,
		logic [NCH-1:0] w, stc_op_type op);
		logic all_m;
		logic any_m;
		all_m = &(~(l ^ w) | ~c);
		any_m = |(~(l ^ w) & c);
		case (op)
			OP_AND: comb_f = all_m;
			OP_OR: comb_f = any_m;
			OP_NAND: comb_f = ~all_m;
			OP_NOR: comb_f = ~any_m;
			default: comb_f = 1'b0;
		endcase
	endfunction : comb_f

	function automatic logic qual_f(logic [TW-1:0] len, stc_cfg_type c);
		case (c.qual)
			Q_TRUE: qual_f = 1'b1;
			Q_LONGER: qual_f = len > c.tmin;
			Q_SHORTER: qual_f = len < c.tmax;
			Q_WITHIN: qual_f = (len >= c.tmin) && (len <= c.tmax);
			default: qual_f = 1'b0;
		endcase
	endfunction : qual_f

	function automatic logic [TW-1:0] inc_f(logic [TW-1:0] x);
		inc_f = (&x) ? x : x + 16'h0001;
	endfunction : inc_f

	always_comb begin
		logic pol, pol_q, pend, clk_edge, crise, srise, pulse_ok;
		above_d = samp_i[cfg_i.src] >= cfg_i.level;
		cond_d = comb_f(lvl_i, cfg_i.care, cfg_i.want, cfg_i.op);
		stop_d = comb_f(lvl_i, cfg_i.stop_care, cfg_i.stop_want, cfg_i.op);
		clkl_d = lvl_i[cfg_i.clk_src];
		pol = cfg_i.slope ? above_d : ~above_d;
		pol_q = cfg_i.slope ? above_q : ~above_q;
		pend = pol_q & ~pol;
		clk_edge = cfg_i.slope ? (clkl_d & ~clkl_q) : (~clkl_d & clkl_q);
		crise = cond_d & ~cond_q;
		srise = stop_d & ~stop_q;
		pw_d = pol ? inc_f(pw_q) : '0;
		pc_d = cond_d ? inc_f(pc_q) : '0;
		run_d = run_q;
		sc_d = run_q ? inc_f(sc_q) : '0;
		case (cfg_i.pwhen)
			W_LESS: pulse_ok = pw_q < cfg_i.tmin;
			W_MORE: pulse_ok = pw_q > cfg_i.tmax;
			W_WITHIN: pulse_ok = (pw_q >= cfg_i.tmin) && (pw_q <= cfg_i.tmax);
			default: pulse_ok = (pw_q < cfg_i.tmin) || (pw_q > cfg_i.tmax);
		endcase
		if (cfg_i.glitch) begin
			pulse_ok = pw_q < cfg_i.tmin;
		end
		hit_d = 1'b0;
		case (cfg_i.ttype)
			TT_EDGE: hit_d = pol & ~pol_q;
			TT_PULSE: hit_d = pend & pulse_ok;
			TT_PATTERN: begin
				if (cfg_i.qual == Q_TRUE) begin
					hit_d = crise;
				end else begin
					hit_d = ~cond_d & cond_q & qual_f(pc_q, cfg_i);
				end
			end
			TT_STATE: hit_d = clk_edge & cond_d;
			TT_SEQUENCE: begin
				if (run_q && srise) begin
					hit_d = qual_f(sc_q, cfg_i);
					run_d = 1'b0;
				end else if (crise) begin
					run_d = 1'b1;
					sc_d = '0;
				end
			end
			default: hit_d = 1'b0;
		endcase
		hit_d = hit_d & en_i;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			above_q <= 1'b0;
			cond_q <= 1'b0;
			stop_q <= 1'b0;
			clkl_q <= 1'b0;
			run_q <= 1'b0;
			hit_q <= 1'b0;
			pw_q <= '0;
			pc_q <= '0;
			sc_q <= '0;
		end else begin
			hit_q <= hit_d;
			if (en_i) begin
				above_q <= above_d;
				cond_q <= cond_d;
				stop_q <= stop_d;
				clkl_q <= clkl_d;
				run_q <= run_d;
				pw_q <= pw_d;
				pc_q <= pc_d;
				sc_q <= sc_d;
			end
		end
	end

	assign hit_o = hit_q;
endmodule : stc_trig_eval

// ### stc_trigger_control.sv
// Trigger controller: arming, modes, holdoff, delay stage and record writes
// Function
// - main and delayed systems share five types
// - edge fires on threshold crossing in direction
// - pulse width or glitch duration must qualify
// - pattern Boolean condition qualified by time
// - state condition sampled at clock edge
// - start then stop within time qualifier
// - normal mode acquires only on trigger
// - manual force gives exactly one acquisition
// - auto mode forces trigger after timeout
// - auto timeout scales with time base
// - further triggers ignored during acquisition
// - holdoff follows each acquisition before re-arm
// - holdoff percent between time base scaled limits
// - trigger position sets pretrigger percentage
// - slope picks rising or falling transition
// - main level only for edge and pulse
// - delay stage waits time, events, or both
// - inputs sampled at fixed regular intervals
// - each sample written with running sample-count timing stamp
// - any of sixteen channels selectable as source
// - armed device keeps pretrigger samples filled
// - record length 500, 1000 or 2000
`timescale 1ns/1ps
module stc_trigger_control import stc_pkg::*; #(
	parameter int AUTO_CYC = AUTO_BASE_CYC
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire stc_samp_type samp_i,
	input wire stc_samp_type thr_i,
	input wire logic run_i,
	input wire logic auto_i,
	input wire logic force_i,
	input wire logic [3:0] tb_i,
	input wire logic [1:0] rec_sel_i,
	input wire logic [6:0] pre_pct_i,
	input wire logic [6:0] ho_pct_i,
	input wire stc_cfg_type main_cfg_i,
	input wire stc_cfg_type dly_cfg_i,
	input wire logic [1:0] dly_mode_i,
	input wire logic [TW-1:0] dly_time_i,
	input wire logic [TW-1:0] dly_evt_i,
	output logic wr_valid_o,
	output stc_wr_type wr_o,
	output logic [31:0] trig_stamp_o,
	output logic trigd_o,
	output logic forced_o,
	output logic armed_o,
	output logic holdoff_o,
	output logic acq_done_o
);
	stc_samp_type s1_q, s2_q;
	logic [2:0] fsync_q;
	logic [NCH-1:0] lvl;
	logic main_hit, dly_hit;

	stc_state_type st_q, st_d;
	logic [15:0] div_q, div_d;
	logic sen_q, sen_d;
	logic [31:0] stamp_q, stamp_d, tstamp_q, tstamp_d, at_q, at_d;
	logic [TW-1:0] cnt_q, cnt_d, ec_q, ec_d;
	logic [RW-1:0] wp_q, wp_d;
	logic fp_q, fp_d, trigd_q, trigd_d, forced_q, forced_d, done_q, done_d;
	logic wv_q, wv_d, armed_q, armed_d, hold_q, hold_d;
	stc_wr_type wr_q, wr_d;

	function automatic logic [RW-1:0] rec_len_f(logic [1:0] sel);
		case (sel)
			2'h0: rec_len_f = REC_LEN_S;
			2'h1: rec_len_f = REC_LEN_M;
			default: rec_len_f = REC_LEN_L;
		endcase
	endfunction : rec_len_f

	function automatic logic [31:0] pct_f(logic [31:0] span, logic [6:0] pct);
		logic [31:0] p;
		p = ({25'h0, pct} > PCT_FULL) ? PCT_FULL : {25'h0, pct};
		pct_f = (span * p) / PCT_FULL;
	endfunction : pct_f

	// Digitized channels arrive from another clock domain
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_q <= '0;
			s2_q <= '0;
			fsync_q <= '0;
		end else begin
			s1_q <= samp_i;
			s2_q <= s1_q;
			fsync_q <= {fsync_q[1:0], force_i};
		end
	end

	// Per-channel logic thresholds for pattern, state and sequence types
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_lvl
			assign lvl[g] = s2_q[g] >= thr_i[g];
		end
	endgenerate

	stc_trig_eval u_main (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.en_i(sen_q),
		.samp_i(s2_q),
		.lvl_i(lvl),
		.cfg_i(main_cfg_i),
		.hit_o(main_hit)
	);

	stc_trig_eval u_dly (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.en_i(sen_q),
		.samp_i(s2_q),
		.lvl_i(lvl),
		.cfg_i(dly_cfg_i),
		.hit_o(dly_hit)
	);

	always_comb begin
		logic [15:0] lim;
		logic [RW-1:0] rec, pre, post;
		logic [31:0] ho, auto_len;
		logic fire, frc, dly_ok;
		lim = (16'h0001 << tb_i) - 16'h0001;
		div_d = (div_q >= lim) ? 16'h0000 : div_q + 16'h0001;
		sen_d = div_q >= lim;
		rec = rec_len_f(rec_sel_i);
		pre = RW'(pct_f({21'h0, rec}, pre_pct_i));
		post = rec - pre;
		ho = {16'h0, HO_MIN_SAMP} + pct_f({16'h0, HO_MAX_SAMP - HO_MIN_SAMP}, ho_pct_i);
		auto_len = 32'(AUTO_CYC) << tb_i;
		st_d = st_q;
		cnt_d = cnt_q;
		ec_d = ec_q;
		stamp_d = sen_q ? stamp_q + 32'h1 : stamp_q;
		tstamp_d = tstamp_q;
		wp_d = wp_q;
		trigd_d = trigd_q;
		forced_d = forced_q;
		done_d = 1'b0;
		at_d = main_hit ? 32'h0 : ((&at_q) ? at_q : at_q + 32'h1);
		fp_d = fp_q | (fsync_q[1] & ~fsync_q[2]);
		wv_d = 1'b0;
		wr_d = wr_q;
		fire = 1'b0;
		frc = 1'b0;
		if (sen_q && (st_q == ST_FILL || st_q == ST_ARMED || st_q == ST_DELAY
			|| st_q == ST_POST)) begin
			wv_d = 1'b1;
			wr_d.data = s2_q;
			wr_d.stamp = stamp_q;
			wr_d.addr = wp_q;
			wp_d = (wp_q >= rec - 11'h001) ? '0 : wp_q + 11'h001;
		end
		dly_ok = (((dly_mode_i & DLY_BY_TIME) == 2'h0) || cnt_q >= dly_time_i)
			&& (((dly_mode_i & DLY_BY_EVT) == 2'h0) || ec_q >= dly_evt_i);
		case (st_q)
			ST_IDLE: begin
				if (run_i) begin
					st_d = ST_FILL;
					cnt_d = '0;
					wp_d = '0;
				end
			end
			ST_FILL: begin
				if (sen_q) begin
					cnt_d = cnt_q + 16'h0001;
				end
				if (cnt_q >= {5'h0, pre}) begin
					st_d = ST_ARMED;
					at_d = '0;
				end
			end
			ST_ARMED: begin
				if (main_hit) begin
					fire = 1'b1;
				end else if (fp_q) begin
					frc = 1'b1;
				end else if (auto_i && at_q >= auto_len) begin
					frc = 1'b1;
				end
				if (fire || frc) begin
					fp_d = fsync_q[1] & ~fsync_q[2];
					trigd_d = fire;
					forced_d = frc;
					cnt_d = '0;
					ec_d = '0;
					tstamp_d = stamp_q;
					st_d = (fire && dly_mode_i != 2'h0) ? ST_DELAY : ST_POST;
				end
			end
			ST_DELAY: begin
				if (sen_q) begin
					cnt_d = inc16(cnt_q);
				end
				if (dly_hit) begin
					ec_d = inc16(ec_q);
				end
				if (dly_ok) begin
					st_d = ST_POST;
					cnt_d = '0;
					tstamp_d = stamp_q;
				end
			end
			ST_POST: begin
				if (sen_q) begin
					cnt_d = cnt_q + 16'h0001;
				end
				if (cnt_q >= {5'h0, post}) begin
					st_d = ST_HOLD;
					cnt_d = '0;
					done_d = 1'b1;
					trigd_d = 1'b0;
					forced_d = 1'b0;
				end
			end
			ST_HOLD: begin
				if (sen_q) begin
					cnt_d = inc16(cnt_q);
				end
				if ({16'h0, cnt_q} >= ho) begin
					st_d = ST_FILL;
					cnt_d = '0;
				end
			end
			default: st_d = ST_IDLE;
		endcase
		if (!run_i) begin
			st_d = ST_IDLE;
			trigd_d = 1'b0;
			forced_d = 1'b0;
		end
		armed_d = (st_d == ST_ARMED);
		hold_d = (st_d == ST_HOLD);
	end

	function automatic logic [TW-1:0] inc16(logic [TW-1:0] x);
		inc16 = (&x) ? x : x + 16'h0001;
	endfunction : inc16

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= ST_IDLE;
			div_q <= '0;
			sen_q <= 1'b0;
			stamp_q <= '0;
			tstamp_q <= '0;
			at_q <= '0;
			cnt_q <= '0;
			ec_q <= '0;
			wp_q <= '0;
			fp_q <= 1'b0;
			trigd_q <= 1'b0;
			forced_q <= 1'b0;
			done_q <= 1'b0;
			wv_q <= 1'b0;
			wr_q <= '0;
			armed_q <= 1'b0;
			hold_q <= 1'b0;
		end else begin
			armed_q <= armed_d;
			hold_q <= hold_d;
			st_q <= st_d;
			div_q <= div_d;
			sen_q <= sen_d;
			stamp_q <= stamp_d;
			tstamp_q <= tstamp_d;
			at_q <= at_d;
			cnt_q <= cnt_d;
			ec_q <= ec_d;
			wp_q <= wp_d;
			fp_q <= fp_d;
			trigd_q <= trigd_d;
			forced_q <= forced_d;
			done_q <= done_d;
			wv_q <= wv_d;
			wr_q <= wr_d;
		end
	end

	assign wr_valid_o = wv_q;
	assign wr_o = wr_q;
	assign trig_stamp_o = tstamp_q;
	assign trigd_o = trigd_q;
	assign forced_o = forced_q;
	assign armed_o = armed_q;
	assign holdoff_o = hold_q;
	assign acq_done_o = done_q;
endmodule : stc_trigger_control

// ### stc_asserts.sv
// Port checker for the trigger controller
`timescale 1ns/1ps
module stc_asserts import stc_pkg::*; #(
	parameter int AUTO_CYC = 20
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [3:0] tb_i,
	input wire logic [1:0] dly_mode_i,
	input wire logic wr_valid_o,
	input wire stc_wr_type wr_o,
	input wire logic [31:0] trig_stamp_o,
	input wire logic trigd_o,
	input wire logic forced_o,
	input wire logic armed_o,
	input wire logic holdoff_o,
	input wire logic acq_done_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	AST_DONE_PULSE: assert property (acq_done_o |=> !acq_done_o)
		else $error("done longer than one cycle");
	AST_HOLD_AFTER_DONE: assert property (acq_done_o |-> ##[0:1] holdoff_o)
		else $error("no holdoff after done");
	AST_HOLD_UNARMED: assert property (holdoff_o |-> !armed_o)
		else $error("armed in holdoff");
	AST_TRIG_FROM_ARMED: assert property ($rose(trigd_o) |-> $past(armed_o))
		else $error("trigger while not armed");
	AST_ONE_KIND: assert property (!(trigd_o && forced_o))
		else $error("trigd and forced together");
	AST_TRIG_STANDS: assert property (trigd_o && !acq_done_o |=> trigd_o || acq_done_o)
		else $error("trigd dropped early");
	AST_ADDR_RANGE: assert property (wr_valid_o |-> wr_o.addr < REC_LEN_L)
		else $error("address beyond record");
	AST_WR_SPACING: assert property (wr_valid_o && tb_i != 4'h0 && $stable(tb_i) |=> !wr_valid_o)
		else $error("writes closer than sample period");
	AST_STAMP_HELD: assert property (trigd_o && $past(trigd_o) && dly_mode_i == 2'h0 |-> $stable(trig_stamp_o))
		else $error("stamp moved");
endmodule : stc_asserts

bind stc_trigger_control stc_asserts #(.AUTO_CYC(AUTO_CYC)) u_ast (.clk_i(clk_i),
	.rst_n_i(rst_n_i), .tb_i(tb_i), .dly_mode_i(dly_mode_i), .wr_valid_o(wr_valid_o),
	.wr_o(wr_o), .trig_stamp_o(trig_stamp_o), .trigd_o(trigd_o), .forced_o(forced_o),
	.armed_o(armed_o), .holdoff_o(holdoff_o), .acq_done_o(acq_done_o));

// ### stc_probe_model.sv
// Probed circuit: one steered channel, the others busy every cycle
`timescale 1ns/1ps
module stc_probe_model import stc_pkg::*; (
	input wire logic clk_i,
	input wire logic [3:0] ch_i,
	input wire logic hi_i,
	output stc_samp_type samp_o
);
	logic [SW-1:0] cnt_q = 8'h00;
	always_ff @(posedge clk_i) cnt_q <= cnt_q + 8'h01;
	always_comb begin
		for (int n = 0; n < NCH; n++) samp_o[n] = cnt_q ^ SW'(n * 37);
		samp_o[ch_i] = hi_i ? 8'hc0 : 8'h20;
	end
endmodule : stc_probe_model

// ### scope_trigger_control_tb.sv
// Self-checking bench for the trigger controller
`timescale 1ns/1ps
module scope_trigger_control_tb import stc_pkg::*;;
	localparam int ARM = 0, HLD = 1, TRG = 2, FRC = 3, DON = 4;
	logic clk_i = 1'b0, rst_n_i = 1'b0, run_i = 1'b0, auto_i = 1'b0, force_i = 1'b0;
	logic hi = 1'b0, st_q = 1'b0;
	logic [3:0] tb_i = 4'h0;
	logic [1:0] rec_sel_i = 2'h0, dly_mode_i = 2'h0;
	logic [TW-1:0] dly_time_i = 16'h0000, dly_evt_i = 16'h0000;
	logic [31:0] trig_stamp_o;
	stc_wr_type wr;
	logic [6:0] pre_pct_i = 7'h32, ho_pct_i = 7'h00, pct;
	logic [31:0] seed = 32'h7160f965;
	logic wr_valid_o, trigd_o, forced_o, armed_o, holdoff_o, acq_done_o;
	logic [4:0] mon;
	logic [1:0] exp_q[$];
	stc_cfg_type cfg = '0;
	stc_samp_type samp;
	int n_errors = 0, num_checks = 0, wr_cnt = 0, n, len, ho = 10;
	assign mon = {acq_done_o, forced_o, trigd_o, holdoff_o, armed_o};
	initial forever #5 clk_i = ~clk_i;
	stc_probe_model u_probe (.clk_i(clk_i), .ch_i(cfg.src), .hi_i(hi), .samp_o(samp));
	stc_trigger_control #(.AUTO_CYC(20)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.samp_i(samp), .thr_i({NCH{8'h80}}), .run_i(run_i), .auto_i(auto_i),
		.force_i(force_i), .tb_i(tb_i), .rec_sel_i(rec_sel_i), .pre_pct_i(pre_pct_i),
		.ho_pct_i(ho_pct_i), .main_cfg_i(cfg), .dly_cfg_i('0), .dly_mode_i(dly_mode_i),
		.dly_time_i(dly_time_i), .dly_evt_i(dly_evt_i), .wr_valid_o(wr_valid_o), .wr_o(wr),
		.trig_stamp_o(trig_stamp_o), .trigd_o(trigd_o), .forced_o(forced_o), .armed_o(armed_o),
		.holdoff_o(holdoff_o), .acq_done_o(acq_done_o));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : final_report
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g, input int t);
		num_checks++;
		if ($isunknown(g) || g + t < e || g > e + t) begin
			n_errors++;
			$display("CHECK FAILED %s expected %0d seen %0d", what, e, g);
		end
	endtask : chk
	task automatic wait_v(input int k, input logic v, output int c);
		c = 0;
		while (mon[k] !== v) begin
			@(posedge clk_i);
			#1;
			c++;
			if (c > 9000) begin
				chk("wait bound", 0, 1, 0);
				final_report();
			end
		end
	endtask : wait_v
	always @(negedge clk_i) begin
		if (wr_valid_o === 1'b1) wr_cnt <= wr_cnt + 1;
		if ((trigd_o | forced_o) === 1'b1 && !st_q) begin
			if (exp_q.size() == 0) chk("extra acquisition", 0, 1, 0);
			else chk("trigd forced", exp_q.pop_front(), {trigd_o, forced_o}, 0);
			chk("trig stamp", wr.stamp, trig_stamp_o, 2);
		end
		st_q <= trigd_o | forced_o;
	end
	initial begin
		cfg.level = 8'h80;
		repeat (10) @(posedge clk_i);
		#1 rst_n_i = 1'b1;
		run_i = 1'b1;
		wait_v(ARM, 1'b1, n);
		chk("pre count", 250, wr_cnt, 2);
		repeat (500) @(posedge clk_i);
		#1;
		chk("still armed", 1, armed_o, 0);
		$display("test normal quiet done");
		exp_q.push_back(2'b01);
		force_i = 1'b1;
		repeat (4) @(posedge clk_i);
		#1 force_i = 1'b0;
		wait_v(FRC, 1'b1, n);
		wr_cnt = 0;
		wait_v(DON, 1'b1, n);
		chk("post count", 250, wr_cnt, 2);
		$display("test force done");
		for (int i = 0; i < 3; i++) begin
			seed = xs(seed);
			pct = 7'(10 + seed[15:8] % 81);
			len = i == 0 ? 500 : i == 1 ? 1000 : 2000;
			wait_v(HLD, 1'b1, n);
			rec_sel_i = 2'(i);
			pre_pct_i = pct;
			cfg.slope = i[0];
			cfg.src = seed[3:0];
			hi = cfg.slope;
			wait_v(HLD, 1'b0, n);
			chk("holdoff cycles", ho, n, 3);
			wr_cnt = 0;
			wait_v(ARM, 1'b1, n);
			chk("pre count", len * pct / 100, wr_cnt, 2);
			hi = ~cfg.slope;
			repeat (20) @(posedge clk_i);
			#1 exp_q.push_back(2'b10);
			hi = cfg.slope;
			wait_v(TRG, 1'b1, n);
			chk("edge latency", 4, n, 2);
			wr_cnt = 0;
			ho_pct_i = 7'(50 * i);
			hi = ~cfg.slope;
			repeat (5) @(posedge clk_i);
			#1 hi = cfg.slope;
			wait_v(DON, 1'b1, n);
			chk("post count", len - len * pct / 100, wr_cnt, 2);
			ho = 10 + 3990 * 50 * i / 100;
			$display("test edge %0d done", i);
		end
		wait_v(HLD, 1'b1, n);
		auto_i = 1'b1;
		tb_i = 4'h1;
		rec_sel_i = 2'h0;
		wait_v(HLD, 1'b0, n);
		wait_v(ARM, 1'b1, n);
		exp_q.push_back(2'b01);
		wait_v(FRC, 1'b1, n);
		chk("auto timeout", 20 << 1, n, 3);
		wait_v(DON, 1'b1, n);
		run_i = 1'b0;
		repeat (5) @(posedge clk_i);
		$display("test auto done");
		final_report();
	end
endmodule : scope_trigger_control_tb
